// *** pmbus_fault_seq_status_cmds_tb.sv ***
`timescale 1ns/1ps
module pmbus_fault_seq_status_cmds_tb;
  import pmfs_pkg::*;
  // One setting: code, reset value, byte wide, paged
  typedef struct packed {
    logic [7:0] code;
    logic [15:0] rst;
    logic byt;
    logic pg;
  } pmfs_row_t;
  localparam int NROW = 20;
  localparam int LIMIT = 10000;
  localparam pmfs_row_t ROWS [NROW] = '{
    '{8'h44, 16'h0e66, 1'b0, 1'b1}, '{8'h45, 16'h00b8, 1'b1, 1'b1},
    '{8'h46, 16'hdbb8, 1'b0, 1'b1},
    '{8'h47, 16'h0000, 1'b1, 1'b1},
    '{8'h4a, 16'hda80, 1'b0, 1'b1},
    '{8'h4f, 16'heb20, 1'b0, 1'b1},
    '{8'h50, 16'h00b8, 1'b1, 1'b1},
    '{8'h51, 16'heaa8, 1'b0, 1'b1},
    '{8'h53, 16'he580, 1'b0, 1'b1},
    '{8'h54, 16'h00b8, 1'b1, 1'b1},
    '{8'h55, 16'hd3e0, 1'b0, 1'b0}, '{8'h56, 16'h0080, 1'b1, 1'b1},
    '{8'h58, 16'hcb26, 1'b0, 1'b0},
    '{8'h60, 16'h8000, 1'b0, 1'b1},
    '{8'h61, 16'hd200, 1'b0, 1'b1},
    '{8'h62, 16'hd280, 1'b0, 1'b1},
    '{8'h63, 16'h00b8, 1'b1, 1'b1},
    '{8'h64, 16'h8000, 1'b0, 1'b1},
    '{8'h65, 16'hd200, 1'b0, 1'b1},
    '{8'h66, 16'hf258, 1'b0, 1'b1}};
  // Design connections
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pmfs_cmd_t cmd;
  pmfs_rsp_t rsp;
  logic store = 1'b0;
  logic restore = 1'b0;
  logic [1:0] run = 2'b00;
  logic [1:0] above = 2'b00;
  logic [1:0] below = 2'b00;
  pmfs_evt_t [1:0] evt = '0;
  logic vin_ov = 1'b0;
  logic vin_uv = 1'b0;
  logic [1:0] drive_en, ramp_up, ramp_down, ton_fault, toff_warn;
  logic page;
  // Bench state
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  pmfs_rsp_t r;
  // Sequencer outputs in one vector for the wait helper
  wire logic [7:0] mon = {ramp_up, ramp_down, ton_fault, toff_warn};

  always #10 clk = ~clk;

  pmfs_host i_host (.i_clk(clk), .i_rsp(rsp), .o_cmd(cmd));

  pmfs_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .o_rsp(rsp),
    .i_nvm_store(store), .i_nvm_restore(restore), .i_run(run),
    .i_vout_above_uv(above), .i_vout_below_decay(below), .i_evt(evt),
    .i_vin_ov_fault(vin_ov), .i_vin_uv_warn(vin_uv),
    .o_drive_en(drive_en), .o_ramp_up(ramp_up), .o_ramp_down(ramp_down),
    .o_ton_fault(ton_fault), .o_toff_warn(toff_warn), .o_page(page));

  // Verdict, reached from the main flow or the hang guard
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string m);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Command with answer check; read data only checked on reads
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d,
    input logic e, input logic [15:0] x, input string m);
    i_host.xfer(w, c, d, r);
    chk({14'h0000, r.valid, r.err}, {14'h0000, 1'b1, e}, m);
    if (!w)
      chk(r.data, x, m);
  endtask

  // Step to just after the next edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Bounded wait for one monitor bit, with an earliest allowed cycle
  task automatic wait_hi(input int b, input int lo, input int hi,
    input string m);
    int n;
    n = 0;
    while (mon[b] !== 1'b1 && n < hi)
    begin
      tick();
      n++;
    end
    chk({15'h0000, mon[b]}, 16'h0001, m);
    chk({15'h0000, n >= lo}, 16'h0001, m);
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    repeat (20) tick();
    rst_n = 1'b1;
    tick();
    chk({5'h00, drive_en, ramp_up, ramp_down, ton_fault, toff_warn, page},
      16'h0000, "outputs after reset");
    // Reset values, then per-page copies
    for (int i = 0; i < NROW; i++)
      op(1'b0, ROWS[i].code, 16'h0000, 1'b0, ROWS[i].rst, "reset");
    op(1'b1, CMD_PAGE, 16'h0001, 1'b0, 16'h0000, "page");
    chk({15'h0000, page}, 16'h0001, "page select");
    for (int i = 0; i < NROW; i++)
    begin
      op(1'b1, ROWS[i].code, {ROWS[i].code, ~ROWS[i].code}, 1'b0,
        16'h0000, "write");
      op(1'b0, ROWS[i].code, 16'h0000, 1'b0, ROWS[i].byt ?
        {8'h00, ~ROWS[i].code} : {ROWS[i].code, ~ROWS[i].code}, "readback");
    end
    op(1'b1, CMD_PAGE, 16'h0000, 1'b0, 16'h0000, "page");
    for (int i = 0; i < NROW; i++)
      op(1'b0, ROWS[i].code, 16'h0000, 1'b0, ROWS[i].pg ? ROWS[i].rst :
        {ROWS[i].code, ~ROWS[i].code}, "page copy");
    $display("test table done");
    // Refusals: unmapped code, page out of range
    op(1'b0, 8'h43, 16'h0000, 1'b1, 16'h0000, "unmapped");
    op(1'b1, CMD_PAGE, 16'h0002, 1'b1, 16'h0000, "bad page");
    chk({15'h0000, page}, 16'h0000, "page kept");
    // Status: overcurrent on channel 0, summaries, clear
    evt[0].oc_fault = 1'b1;
    tick();
    evt[0].oc_fault = 1'b0;
    op(1'b0, CMD_ST_IOUT, 16'h0000, 1'b0, 16'h0080, "iout");
    op(1'b0, CMD_ST_BYTE, 16'h0000, 1'b0, 16'h0050, "byte");
    op(1'b0, CMD_ST_WORD, 16'h0000, 1'b0, 16'h4050, "word");
    op(1'b1, CMD_ST_IOUT, 16'h0080, 1'b0, 16'h0000, "clear");
    op(1'b0, CMD_ST_IOUT, 16'h0000, 1'b0, 16'h0000, "cleared");
    {vin_ov, vin_uv} = 2'h3;
    {evt[1].ot_warn, evt[1].ut_fault} = 2'h3;
    tick();
    {vin_ov, vin_uv} = 2'h0;
    {evt[1].ot_warn, evt[1].ut_fault} = 2'h0;
    op(1'b0, CMD_ST_TEMP, 16'h0000, 1'b0, 16'h0000, "temp ch0");
    op(1'b1, CMD_PAGE, 16'h0001, 1'b0, 16'h0000, "page");
    op(1'b0, CMD_ST_INPUT, 16'h0000, 1'b0, 16'h00a0, "input");
    op(1'b0, CMD_ST_TEMP, 16'h0000, 1'b0, 16'h0050, "temp ch1");
    op(1'b1, CMD_PAGE, 16'h0000, 1'b0, 16'h0000, "page");
    $display("test status done");
    // Image keeps settings across a later write
    op(1'b1, 8'h46, 16'h1111, 1'b0, 16'h0000, "pre store");
    store = 1'b1;
    tick();
    store = 1'b0;
    op(1'b1, 8'h46, 16'h2222, 1'b0, 16'h0000, "post store");
    restore = 1'b1;
    tick();
    restore = 1'b0;
    op(1'b0, 8'h46, 16'h0000, 1'b0, 16'h1111, "restored");
    $display("test image done");
    // Channel 0: rise 7 us, limit 15 us, output never comes up
    op(1'b1, 8'h61, 16'hc002, 1'b0, 16'h0000, "rise");
    op(1'b1, 8'h62, 16'hc004, 1'b0, 16'h0000, "limit");
    run[0] = 1'b1;
    wait_hi(6, 0, 5, "ramp start");
    wait_hi(2, 650, 900, "turn-on timeout");
    tick();
    chk({14'h0000, drive_en}, 16'h0000, "shutdown action");
    run[0] = 1'b0;
    op(1'b0, CMD_ST_VOUT, 16'h0000, 1'b0, 16'h0004, "vout ch0");
    $display("test timeout done");
    // Channel 1: 3 us ramps, 7 us decay limit, output never decays
    // Table left a long on delay on this page, so zero both delays first
    op(1'b1, CMD_PAGE, 16'h0001, 1'b0, 16'h0000, "page");
    op(1'b1, 8'h60, 16'h8000, 1'b0, 16'h0000, "on delay");
    op(1'b1, 8'h64, 16'h8000, 1'b0, 16'h0000, "off delay");
    op(1'b1, 8'h61, 16'hc001, 1'b0, 16'h0000, "rise");
    op(1'b1, 8'h65, 16'hc001, 1'b0, 16'h0000, "fall");
    op(1'b1, 8'h66, 16'hc002, 1'b0, 16'h0000, "decay");
    above[1] = 1'b1;
    run[1] = 1'b1;
    wait_hi(7, 0, 5, "ramp up");
    repeat (250) tick();
    chk({14'h0000, ramp_up[1], drive_en[1]}, 16'h0001, "on");
    run[1] = 1'b0;
    wait_hi(5, 0, 5, "ramp down");
    wait_hi(1, 250, 700, "decay warning");
    op(1'b0, CMD_ST_VOUT, 16'h0000, 1'b0, 16'h0002, "vout ch1");
    chk({15'h0000, drive_en[1]}, 16'h0000, "off");
    $display("test sequence done");
    // Second reset restores defaults
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    op(1'b0, 8'h46, 16'h0000, 1'b0, 16'hdbb8, "second reset");
    $display("test reset done");
    results();
  end
endmodule

// *** pmfs_host.sv ***
`timescale 1ns/1ps
module pmfs_host
  import pmfs_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Command out, answer back
  input wire pmfs_rsp_t i_rsp,
  output pmfs_cmd_t o_cmd
);
  // Idle until the first command
  initial o_cmd = '{valid: 1'b0, write: 1'b0, code: 8'h00, data: 16'h0000};

  // One command; the answer is taken just after the same edge that takes it
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output pmfs_rsp_t r);
    @(posedge i_clk);
    #1;
    // Words already in linear or scaled form; page first for paged codes
    o_cmd = '{valid: 1'b1, write: w, code: c, data: d};
    @(posedge i_clk);
    #1;
    r = i_rsp;
    // Released bus shows junk so a stale command cannot pass
    o_cmd = '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
  endtask
endmodule

// *** pmfs_l11_us.sv ***
`timescale 1ns/1ps
module pmfs_l11_us
  import pmfs_pkg::*;
(
  // Linear time in milliseconds
  input wire logic [15:0] i_val,
  // Same time in whole microseconds
  output logic [31:0] o_us
);
  logic signed [4:0] exp_s; // Exponent field
  logic [4:0] nexp; // Right shift for negative exponent
  logic [20:0] prod; // Mantissa times 1000
  logic [52:0] wide; // Shifted product before saturation

  // Mantissa times two to the exponent; negatives clamp to zero
  always_comb
  begin
    exp_s = i_val[15:11]; // RL19
    nexp = 5'(-exp_s);
    prod = 21'(i_val[9:0]) * MS_TO_US;
    if (exp_s < 0)
      wide = {32'h0000_0000, prod} >> nexp;
    else
      wide = {32'h0000_0000, prod} << exp_s[3:0];
    if (i_val[10])
      o_us = 32'h0000_0000; // Negative time means none
    else if (|wide[52:32])
      o_us = 32'hffff_ffff; // Saturate, never wrap
    else
      o_us = wide[31:0];
  end
endmodule

// *** pmfs_pkg.sv ***
// Overview of operation
// RL1 - Per-channel overcurrent fault threshold, 0x46, 0xDBB8
// RL2 - Per-channel overcurrent fault action byte, 0x47
// RL3 - Per-channel overcurrent warning threshold, 0x4A, 0xDA80
// RL4 - Per-channel overtemperature fault threshold, 0x4F
// RL5 - Per-channel overtemperature fault action byte, 0x50
// RL6 - Per-channel overtemperature warning threshold, 0x51
// RL7 - Per-channel undertemperature fault threshold, 0x53
// RL8 - Per-channel undertemperature fault action byte, 0x54
// RL9 - Run or on: wait turn-on delay first
// RL10 - Then ramp up over programmed rise time
// RL11 - Flag timeout if not above undervolt in time
// RL12 - Apply turn-on timeout action byte at 0x63
// RL13 - Run off or off: wait turn-off delay
// RL14 - Then ramp down over programmed fall time
// RL15 - Warn if output not decayed within limit
// RL16 - Status summary byte 0x78, word 0x79
// RL17 - Input status 0x7C shared, not paged
// RL18 - Temperature 0x7D, voltage 0x7A, current 0x7B
// RL19 - Linear words: 5-bit exponent, 11-bit mantissa
// RL20 - Output-voltage words: unsigned, scaled 2^-12
// RL21 - Paged commands use the selected page
// RL22 - Limits saveable to NVM, status not
package pmfs_pkg;
  // Channel count and table sizes
  localparam int NCH = 2;
  localparam int NPG = 18;
  localparam int NSH = 2;
  localparam int NTM = 7;
  // Clock and microsecond tick
  localparam int CLK_HZ = 32'h02fa_f080;
  localparam int US_PER_S = 32'h000f_4240;
  localparam int US_CYC = CLK_HZ / US_PER_S;
  localparam logic [20:0] MS_TO_US = 21'h0_03e8;
  // Non-table command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_ST_BYTE = 8'h78;
  localparam logic [7:0] CMD_ST_WORD = 8'h79;
  localparam logic [7:0] CMD_ST_VOUT = 8'h7a;
  localparam logic [7:0] CMD_ST_IOUT = 8'h7b;
  localparam logic [7:0] CMD_ST_INPUT = 8'h7c;
  localparam logic [7:0] CMD_ST_TEMP = 8'h7d;
  // Paged setting codes, in slot order
  localparam logic [7:0] PG_CODE [NPG] = '{
    8'h44, 8'h45, 8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h53,
    8'h54, 8'h56, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
  // Paged reset values, in slot order
  localparam logic [15:0] PG_RST [NPG] = '{
    16'h0e66, // RL20
    16'h00b8,
    16'hdbb8, // RL1
    16'h0000, // RL2
    16'hda80, // RL3
    16'heb20, // RL4
    16'h00b8, // RL5
    16'heaa8, // RL6
    16'he580, // RL7
    16'h00b8, // RL8
    16'h0080,
    16'h8000, // RL9
    16'hd200, // RL10
    16'hd280, // RL11
    16'h00b8, // RL12
    16'h8000, // RL13
    16'hd200, // RL14
    16'hf258}; // RL15
  // Slots holding one byte only
  localparam logic [NPG-1:0] PG_BYTE = 18'h0_464a;
  // Non-paged setting codes and resets
  localparam logic [7:0] SH_CODE [NSH] = '{8'h55, 8'h58};
  localparam logic [15:0] SH_RST [NSH] = '{16'hd3e0, 16'hcb26};
  // Named slots
  localparam int SL_OC_THR = 2;
  localparam int SL_OC_ACT = 3;
  localparam int SL_TM0 = 11;
  localparam int TM_ONDLY = 0;
  localparam int TM_RISE = 1;
  localparam int TM_ONMAX = 2;
  localparam int TM_ONACT = 3;
  localparam int TM_OFFDLY = 4;
  localparam int TM_FALL = 5;
  localparam int TM_OFFMAX = 6;
  // Status bit positions
  localparam int SV_TON = 2;
  localparam int SV_TOFF = 1;
  localparam int SI_OCF = 7;
  localparam int SI_OCW = 5;
  localparam int ST_OTF = 7;
  localparam int ST_OTW = 6;
  localparam int ST_UTF = 4;
  localparam int SN_OVF = 7;
  localparam int SN_UVW = 5;
  localparam int SB_OFF = 6;
  localparam int SB_IOC = 4;
  localparam int SB_VIN = 3;
  localparam int SB_TMP = 2;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INP = 13;
  // Command in, answer out
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pmfs_cmd_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } pmfs_rsp_t;
  // Monitor events of one channel
  typedef struct packed {
    logic oc_fault;
    logic oc_warn;
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
  } pmfs_evt_t;
  // Sequencer states
  typedef enum logic [2:0] {
    SQ_OFF, SQ_ON_DLY, SQ_RISE, SQ_ON, SQ_OFF_DLY, SQ_FALL, SQ_DECAY
  } pmfs_seq_t;
endpackage

// *** pmfs_top.sv ***
`timescale 1ns/1ps
module pmfs_top
  import pmfs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Command transport
  input wire pmfs_cmd_t i_cmd,
  output pmfs_rsp_t o_rsp,
  // Nonvolatile image control
  input wire logic i_nvm_store,
  input wire logic i_nvm_restore,
  // Channel controls and monitors
  input wire logic [NCH-1:0] i_run,
  input wire logic [NCH-1:0] i_vout_above_uv,
  input wire logic [NCH-1:0] i_vout_below_decay,
  input wire pmfs_evt_t [NCH-1:0] i_evt,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_uv_warn,
  // Channel drive and sequence
  output logic [NCH-1:0] o_drive_en,
  output logic [NCH-1:0] o_ramp_up,
  output logic [NCH-1:0] o_ramp_down,
  output logic [NCH-1:0] o_ton_fault,
  output logic [NCH-1:0] o_toff_warn,
  output logic o_page
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [15:0] pg_reg [NCH][NPG]; // Paged settings
  logic [15:0] sh_reg [NSH]; // Non-paged settings
  logic [15:0] pg_nvm [NCH][NPG]; // Saved paged image
  logic [15:0] sh_nvm [NSH]; // Saved non-paged image
  logic page_reg; // Selected channel
  logic [7:0] st_vout [NCH]; // Sticky voltage status
  logic [7:0] st_iout [NCH]; // Sticky current status
  logic [7:0] st_temp [NCH]; // Sticky temperature status
  logic [7:0] st_input_reg; // Shared input status
  logic [NCH-1:0] seq_off; // Channel at rest
  logic [5:0] presc_reg; // Microsecond prescaler
  logic tick_reg; // One pulse per microsecond
  logic hit_pg; // Code is a paged setting
  logic hit_sh; // Code is a shared setting
  logic [4:0] slot; // Paged slot of the code
  logic sslot; // Shared slot of the code
  logic wr; // Write command this cycle
  logic rd; // Read command this cycle
  logic known; // Code is mapped
  logic bad_page; // Page write out of range
  logic [15:0] rdata; // Read mux result
  logic [7:0] sbyte; // Summary byte of the page

  // Command decode against both tables
  always_comb
  begin
    hit_pg = 1'b0;
    hit_sh = 1'b0;
    slot = 5'h00;
    sslot = 1'b0;
    for (int i = 0; i < NPG; i++)
      if (i_cmd.code == PG_CODE[i])
      begin
        hit_pg = 1'b1;
        slot = 5'(i);
      end
    for (int i = 0; i < NSH; i++)
      if (i_cmd.code == SH_CODE[i])
      begin
        hit_sh = 1'b1;
        sslot = 1'(i);
      end
  end

  assign wr = i_cmd.valid && i_cmd.write;
  assign rd = i_cmd.valid && !i_cmd.write;
  assign known = hit_pg || hit_sh || (i_cmd.code == CMD_PAGE)
    || (i_cmd.code >= CMD_ST_BYTE && i_cmd.code <= CMD_ST_TEMP);
  // Only channel 0 and 1 exist
  assign bad_page = i_cmd.code == CMD_PAGE && |i_cmd.data[7:1];

  // Page selector, itself not paged
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      page_reg <= 1'b0;
    else if (wr && i_cmd.code == CMD_PAGE && !bad_page)
      page_reg <= i_cmd.data[0]; // RL21
  end

  // Settings: reset, restore from image, or host write
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < NCH; c++)
        for (int i = 0; i < NPG; i++)
          pg_reg[c][i] <= PG_RST[i];
      for (int i = 0; i < NSH; i++)
        sh_reg[i] <= SH_RST[i];
    end
    else if (i_nvm_restore)
    begin
      pg_reg <= pg_nvm; // RL22
      sh_reg <= sh_nvm;
    end
    else if (wr && hit_pg)
    begin
      // Byte commands keep the upper half at zero
      if (PG_BYTE[slot])
        pg_reg[page_reg][slot] <= {8'h00, i_cmd.data[7:0]}; // RL2
      else
        pg_reg[page_reg][slot] <= i_cmd.data; // RL21
    end
    else if (wr && hit_sh)
      sh_reg[sslot] <= i_cmd.data; // RL17
  end

  // Image of the nonvolatile store; status never enters it
  // Volatile stand-in: the real store lies outside this block
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < NCH; c++)
        for (int i = 0; i < NPG; i++)
          pg_nvm[c][i] <= PG_RST[i];
      for (int i = 0; i < NSH; i++)
        sh_nvm[i] <= SH_RST[i];
    end
    else if (i_nvm_store)
    begin
      pg_nvm <= pg_reg; // RL22
      sh_nvm <= sh_reg;
    end
  end

  // Microsecond tick shared by all timers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      presc_reg <= 6'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= presc_reg == 6'(US_CYC - 1);
      presc_reg <= (presc_reg == 6'(US_CYC - 1)) ? 6'h00 : presc_reg + 6'h01;
    end
  end

  // Shared input status, set wins over write-one clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st_input_reg <= 8'h00;
    else
    begin
      st_input_reg <= (st_input_reg
        & ~((wr && i_cmd.code == CMD_ST_INPUT) ? i_cmd.data[7:0] : 8'h00))
        | (8'(i_vin_ov_fault) << SN_OVF) | (8'(i_vin_uv_warn) << SN_UVW);
    end
  end

  genvar c, k;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      logic [31:0] tm_us [NTM]; // Timing words in microseconds
      pmfs_seq_t st_reg; // Sequencer state
      pmfs_seq_t st_next; // Its next value
      logic [31:0] cnt_reg; // Microseconds in present state
      logic ton_flt; // Turn-on timeout this cycle
      logic toff_w; // Turn-off decay timeout this cycle
      logic clr_sel; // Status clear aimed at this page
      logic drv_reg, up_reg, dn_reg, tf_reg, tw_reg;

      // One converter for each timing word
      for (k = 0; k < NTM; k++)
      begin : g_tm
        pmfs_l11_us u_conv (
          .i_val(pg_reg[c][SL_TM0 + k]),
          .o_us(tm_us[k])
        );
      end

      // Power-up and power-down sequence
      always_comb
      begin
        st_next = st_reg;
        ton_flt = 1'b0;
        toff_w = 1'b0;
        unique case (st_reg)
          SQ_OFF:
            if (i_run[c])
              st_next = SQ_ON_DLY; // RL9
          SQ_ON_DLY:
            if (!i_run[c])
              st_next = SQ_OFF;
            else if (cnt_reg >= tm_us[TM_ONDLY])
              st_next = SQ_RISE; // RL9
          SQ_RISE:
            if (!i_run[c])
              st_next = SQ_OFF_DLY;
            else if (!i_vout_above_uv[c] && cnt_reg >= tm_us[TM_ONMAX])
            begin
              ton_flt = 1'b1; // RL11
              // Zero action ignores, anything else shuts down
              st_next = (pg_reg[c][SL_TM0 + TM_ONACT] == 16'h0000)
                ? SQ_ON : SQ_OFF; // RL12
            end
            else if (i_vout_above_uv[c] && cnt_reg >= tm_us[TM_RISE])
              st_next = SQ_ON; // RL10
          SQ_ON:
            if (!i_run[c])
              st_next = SQ_OFF_DLY; // RL13
          SQ_OFF_DLY:
            if (cnt_reg >= tm_us[TM_OFFDLY])
              st_next = SQ_FALL; // RL13
          SQ_FALL:
            if (cnt_reg >= tm_us[TM_FALL])
              st_next = SQ_DECAY; // RL14
          SQ_DECAY:
            if (i_vout_below_decay[c])
              st_next = SQ_OFF;
            else if (cnt_reg >= tm_us[TM_OFFMAX])
            begin
              toff_w = 1'b1; // RL15
              st_next = SQ_OFF;
            end
          default:
            st_next = SQ_OFF; // Three-bit code has an illegal value
        endcase
      end

      // State and elapsed time; timer restarts on every change
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          st_reg <= SQ_OFF;
          cnt_reg <= 32'h0000_0000;
        end
        else
        begin
          st_reg <= st_next;
          if (st_next != st_reg)
            cnt_reg <= 32'h0000_0000;
          else if (tick_reg && cnt_reg != 32'hffff_ffff)
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
      end

      // Registered drive and event outputs
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          drv_reg <= 1'b0;
          up_reg <= 1'b0;
          dn_reg <= 1'b0;
          tf_reg <= 1'b0;
          tw_reg <= 1'b0;
        end
        else
        begin
          drv_reg <= st_next inside {SQ_RISE, SQ_ON, SQ_OFF_DLY, SQ_FALL};
          up_reg <= st_next == SQ_RISE; // RL10
          dn_reg <= st_next == SQ_FALL; // RL14
          tf_reg <= ton_flt;
          tw_reg <= toff_w;
        end
      end

      assign o_drive_en[c] = drv_reg;
      assign o_ramp_up[c] = up_reg;
      assign o_ramp_down[c] = dn_reg;
      assign o_ton_fault[c] = tf_reg;
      assign o_toff_warn[c] = tw_reg;
      assign seq_off[c] = st_reg == SQ_OFF;
      assign clr_sel = wr && page_reg == 1'(c);

      // Sticky status per channel; a new event beats a clear
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          st_vout[c] <= 8'h00; // RL22
          st_iout[c] <= 8'h00;
          st_temp[c] <= 8'h00;
        end
        else
        begin
          st_vout[c] <= (st_vout[c] & ~((clr_sel && i_cmd.code ==
            CMD_ST_VOUT) ? i_cmd.data[7:0] : 8'h00))
            | (8'(ton_flt) << SV_TON) | (8'(toff_w) << SV_TOFF); // RL18
          st_iout[c] <= (st_iout[c] & ~((clr_sel && i_cmd.code ==
            CMD_ST_IOUT) ? i_cmd.data[7:0] : 8'h00))
            | (8'(i_evt[c].oc_fault) << SI_OCF)
            | (8'(i_evt[c].oc_warn) << SI_OCW); // RL18
          st_temp[c] <= (st_temp[c] & ~((clr_sel && i_cmd.code ==
            CMD_ST_TEMP) ? i_cmd.data[7:0] : 8'h00))
            | (8'(i_evt[c].ot_fault) << ST_OTF)
            | (8'(i_evt[c].ot_warn) << ST_OTW)
            | (8'(i_evt[c].ut_fault) << ST_UTF); // RL18
        end
      end

      // Delay ended while the request still stands
      sequence s_dly_done;
        st_reg == SQ_ON_DLY && i_run[c] && cnt_reg >= tm_us[TM_ONDLY];
      endsequence
      a_rise_after_delay: assert property (s_dly_done |=> // RL9
        st_reg == SQ_RISE && o_ramp_up[c])
        else $error("ramp did not start after on delay");
      a_ton_timeout: assert property ( // RL11
        st_reg == SQ_RISE && i_run[c] && !i_vout_above_uv[c]
        && cnt_reg >= tm_us[TM_ONMAX] |=> o_ton_fault[c]
        && st_vout[c][SV_TON])
        else $error("turn-on timeout not flagged");
      a_ton_action: assert property ( // RL12
        o_ton_fault[c] && pg_reg[c][SL_TM0 + TM_ONACT] != 16'h0000
        |-> seq_off[c])
        else $error("turn-on timeout action not applied");
      a_fall_after_delay: assert property ( // RL13
        st_reg == SQ_OFF_DLY && cnt_reg >= tm_us[TM_OFFDLY]
        |=> o_ramp_down[c] ##1 o_ramp_down[c] || st_reg == SQ_DECAY)
        else $error("fall ramp did not start after off delay");
      a_decay_warn: assert property ( // RL15
        st_reg == SQ_DECAY && !i_vout_below_decay[c]
        && cnt_reg >= tm_us[TM_OFFMAX] |=> o_toff_warn[c] ##1 !o_toff_warn[c])
        else $error("decay warning missing or not a pulse");
      a_rise_length: assert property ( // RL10
        st_reg == SQ_RISE && i_run[c] && cnt_reg < tm_us[TM_RISE]
        && cnt_reg < tm_us[TM_ONMAX] |=> o_ramp_up[c] && o_drive_en[c])
        else $error("ramp up ended before rise time");
    end
  endgenerate

  // Summary byte of the selected page
  always_comb
  begin
    sbyte = 8'h00;
    sbyte[SB_OFF] = seq_off[page_reg];
    sbyte[SB_IOC] = st_iout[page_reg][SI_OCF];
    sbyte[SB_VIN] = st_input_reg[SN_UVW];
    sbyte[SB_TMP] = |st_temp[page_reg];
  end

  // Read mux: paged codes and per-channel status follow the page; shared settings, page and input status do not
  always_comb
  begin
    rdata = 16'h0000;
    if (hit_pg)
      rdata = pg_reg[page_reg][slot]; // RL21
    else if (hit_sh)
      rdata = sh_reg[sslot];
    else
      unique case (i_cmd.code)
        CMD_PAGE:
          rdata = {15'h0000, page_reg};
        CMD_ST_BYTE:
          rdata = {8'h00, sbyte}; // RL16
        CMD_ST_WORD:
        begin
          rdata = {8'h00, sbyte}; // RL16
          rdata[SW_VOUT] = |st_vout[page_reg];
          rdata[SW_IOUT] = |st_iout[page_reg];
          rdata[SW_INP] = |st_input_reg;
        end
        CMD_ST_VOUT:
          rdata = {8'h00, st_vout[page_reg]}; // RL18
        CMD_ST_IOUT:
          rdata = {8'h00, st_iout[page_reg]}; // RL18
        CMD_ST_INPUT:
          rdata = {8'h00, st_input_reg}; // RL17
        CMD_ST_TEMP:
          rdata = {8'h00, st_temp[page_reg]}; // RL18
        default:
          rdata = 16'h0000; // Unmapped code reads zero
      endcase
  end

  // Answer one cycle after every command
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rsp <= '0;
      o_page <= 1'b0;
    end
    else
    begin
      o_rsp.valid <= i_cmd.valid;
      o_rsp.err <= i_cmd.valid && (!known || (wr && bad_page));
      o_rsp.data <= rd ? rdata : 16'h0000;
      o_page <= (wr && i_cmd.code == CMD_PAGE && !bad_page)
        ? i_cmd.data[0] : page_reg;
    end
  end

  // Own disable: the default one would silence this check in reset
  a_reset_defaults: assert property (disable iff (1'b0) // RL1
    !i_rst_n |=> pg_reg[0][SL_OC_THR] == 16'hdbb8
    && pg_reg[1][SL_OC_THR] == 16'hdbb8)
    else $error("overcurrent threshold reset value wrong");
  a_byte_action: assert property ( // RL2
    wr && i_cmd.code == PG_CODE[SL_OC_ACT] && !i_nvm_restore
    |=> pg_reg[page_reg][SL_OC_ACT] == {8'h00, $past(i_cmd.data[7:0])})
    else $error("byte action not stored as one byte");
  a_page_isolated: assert property ( // RL21
    wr && hit_pg && page_reg && !i_nvm_restore
    |=> pg_reg[0][$past(slot)] == $past(pg_reg[0][slot]))
    else $error("write leaked into unselected page");
  a_input_shared: assert property ( // RL17
    rd && i_cmd.code == CMD_ST_INPUT |=> o_rsp.data[7:0]
    == $past(st_input_reg))
    else $error("input status read wrong");
  a_set_wins: assert property ( // RL18
    i_evt[0].oc_fault |=> st_iout[0][SI_OCF])
    else $error("overcurrent event lost");
  a_read_answer: assert property ( // RL16
    rd && i_cmd.code == CMD_ST_BYTE |=> o_rsp.valid && !o_rsp.err
    && o_rsp.data[15:8] == 8'h00)
    else $error("status byte answer malformed");
  a_restore: assert property ( // RL22
    i_nvm_restore |=> pg_reg[1][SL_OC_THR] == $past(pg_nvm[1][SL_OC_THR]))
    else $error("restore did not load saved image");
endmodule
